// *** pkg/pad_mux_consts.svh ***
// Purpose: Offsets, field positions and reset values of the pad mux
// Assumes: Register offsets are byte addresses on a 32-bit word bus
// Notes:   Definitions only
`ifndef PAD_MUX_CONSTS_SVH
`define PAD_MUX_CONSTS_SVH

// Pad population
`define PAD_COUNT        25
`define ANALOG_COUNT     19
`define FAST_COMP_COUNT  6
`define JTAG_PAD_FIRST   19
`define JTAG_PAD_LAST    23

// Register byte offsets
`define OFS_FUNC_LOW     8'h00
`define OFS_FUNC_HIGH    8'h04
`define OFS_PULLUP       8'h08
`define OFS_CLOCK_RATIO  8'h0c
`define OFS_PAD_LEVELS   8'h10
`define OFS_STATUS       8'h14

// Field widths
`define FUNC_LOW_PADS    16
`define FUNC_HIGH_WIDTH  18
`define RATIO_WIDTH      2

// Reset values
`define FUNC_RESET       50'h0
`define PULLUP_RESET     25'h0d00000
`define RATIO_RESET      2'h0

`endif

// *** pkg/pad_mux_pkg.sv ***
// Purpose: Types shared by the pad mux and its clock divider
// Assumes: Nothing beyond SystemVerilog 2012
// Notes:   Numbers live in pad_mux_consts.svh
`default_nettype none

package pad_mux_pkg;

  // Per-pad function selection
  typedef enum logic [1:0] {
    FUNC_ZERO,
    FUNC_ONE,
    FUNC_TWO,
    FUNC_THREE
  } pad_func_e;

  // System clock output ratio
  typedef enum logic [1:0] {
    RATIO_ONE,
    RATIO_TWO,
    RATIO_FOUR
  } clock_ratio_e;

endpackage

`default_nettype wire

// *** src/sys_clock_divider.sv ***
// Purpose: Divides the system clock by 1, 2 or 4 for the output pin
// Assumes: Ratio is static while the pin is in use
// Notes:   Ratio code 3 behaves as divide by four
`default_nettype none

module sys_clock_divider (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rstn,
  // Ratio selection
  input  wire logic [1:0]  ratio,
  // Divided clock
  output logic             dividedClock
);

  logic [1:0] count;
  logic [1:0] next_count;

  // Free-running count, its bits give the halved and quartered clocks
  always_comb begin
    next_count = count + 2'h1;
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      count <= 2'h0;
    end else begin
      count <= next_count;
    end
  end

  // Undivided ratio passes the clock itself, a flop cannot make it
  always_comb begin
    case (pad_mux_pkg::clock_ratio_e'(ratio))
      pad_mux_pkg::RATIO_ONE: dividedClock = clock;
      pad_mux_pkg::RATIO_TWO: dividedClock = count[0];
      default:                dividedClock = count[1];
    endcase
  end

endmodule

`default_nettype wire

// *** src/pad_function_multiplexer.sv ***
// Purpose: Routes one internal function to each of 25 shared pads
// Assumes: Pad inputs and control inputs are synchronous to clock
// Notes:   Pad state is registered so it can be frozen in low power
// Contract
// R1 - Pads come up as inputs, TDO tristated
// R2 - Pull-ups off at reset except TAP inputs; code leaves TCK pad 21 without one, pulling only pads 20, 22, 23
// R3 - Pad state frozen during low power
// R4 - All pads select function zero at boot
// R5 - Pads 19-23: TAP on zero, GPIO on one
// R6 - Fixed function table per pad group
// R7 - Only the selected function reaches a pad
// R8 - System clock pin divided 1, 2 or 4
// R9 - RTC pin carries undivided RTC clock
// R10 - Internal reset follows external reset pin
// R11 - Battery rail power cycle forces reset
// R12 - Fast comparators off in low power
// R13 - Four functions selectable per pad
// R14 - Unselected peripheral inputs get inactive level
`include "pad_mux_consts.svh"
`default_nettype none

module pad_function_multiplexer (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rstn,
  // Register port
  input  wire logic [7:0]  regAddr,
  input  wire logic [31:0] regWdata,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  output logic      [31:0] regRdata,
  // Pads
  input  wire logic [24:0] padIn,
  output logic      [24:0] padOut,
  output logic      [24:0] padOe,
  output logic      [24:0] padPullup,
  // Power and reset
  input  wire logic        lowPower,
  input  wire logic        resetPinLevel,
  input  wire logic        batterySupplyRailCycle,
  output logic             internalResetN,
  input  wire logic        rtcClock,
  // Analog inputs
  output logic      [18:0] analogInputs,
  output logic      [18:0] comparatorPowerOn,
  // General-purpose lines
  input  wire logic [24:0] gpioOut,
  input  wire logic [24:0] gpioOe,
  output logic      [24:0] gpioIn,
  // Serial master
  input  wire logic [3:0]  spiMasterSelectN,
  input  wire logic        spiMasterClock,
  input  wire logic        spiMasterTx,
  output logic             spiMasterRx,
  // Two-wire, open drain
  input  wire logic        i2cSclDriveLow,
  input  wire logic        i2cSdaDriveLow,
  output logic             i2cSclIn,
  output logic             i2cSdaIn,
  // Serial slave
  input  wire logic        spiSlaveTx,
  input  wire logic        spiSlaveTxOe,
  output logic             spiSlaveClock,
  output logic             spiSlaveRx,
  output logic             spiSlaveSelectN,
  // Asynchronous serial, index 0 is A, index 1 is B
  input  wire logic [1:0]  uartTx,
  input  wire logic [1:0]  uartRtsDe,
  input  wire logic [1:0]  uartCtsReOut,
  input  wire logic [1:0]  uartCtsReOe,
  output logic      [1:0]  uartRx,
  output logic      [1:0]  uartCts,
  // Pulse outputs
  input  wire logic        pulseOutputZero,
  input  wire logic        pulseOutputOne,
  // Test access port
  input  wire logic        jtagTdo,
  input  wire logic        jtagTdoOe,
  output logic             jtagTrstN,
  output logic             jtagTck,
  output logic             jtagTms,
  output logic             jtagTdi
);

  // Two bits per pad, pad n at bits 2n+1:2n
  logic [49:0] funcSel;
  logic [49:0] next_funcSel;
  logic [24:0] pullupCfg;
  logic [24:0] next_pullupCfg;
  logic [1:0]  clockRatio;
  logic [1:0]  next_clockRatio;
  logic [31:0] next_regRdata;

  logic [24:0] padOutReg;
  logic [24:0] next_padOutReg;
  logic [24:0] next_padOe;
  logic [24:0] next_padPullup;

  logic [24:0] liveOut;
  logic [24:0] liveOe;
  logic [24:0] altOut;
  logic [24:0] altOe;
  logic [24:0] gpioSel;
  logic [24:0] altSel;
  logic        dividedClock;

  // Function field of one pad
  function automatic pad_mux_pkg::pad_func_e selOf(
    input logic [49:0] f,
    input int          idx
  );
    return pad_mux_pkg::pad_func_e'(f[2*idx +: 2]);
  endfunction

  // Pads that carry the test access port on function zero
  function automatic logic isJtagPad(input int idx);
    return (idx >= `JTAG_PAD_FIRST) && (idx <= `JTAG_PAD_LAST);
  endfunction

  sys_clock_divider u_divider (
    .clock        (clock),
    .rstn         (rstn),
    .ratio        (clockRatio),
    .dividedClock (dividedClock)
  );

  // Register writes; four functions per pad, two bits each
  always_comb begin
    next_funcSel    = funcSel;
    next_pullupCfg  = pullupCfg;
    next_clockRatio = clockRatio;
    if (regWrite) begin
      case (regAddr)
        `OFS_FUNC_LOW:    next_funcSel[31:0] = regWdata; // R13
        `OFS_FUNC_HIGH:
          next_funcSel[49:32] = regWdata[`FUNC_HIGH_WIDTH-1:0]; // R13
        `OFS_PULLUP:      next_pullupCfg = regWdata[24:0];
        `OFS_CLOCK_RATIO:
          next_clockRatio = regWdata[`RATIO_WIDTH-1:0];
        default:          next_funcSel = funcSel;
      endcase
    end
  end

  // Reads answer one cycle later; unmapped offsets read zero
  always_comb begin
    next_regRdata = 32'h0;
    if (regRead) begin
      case (regAddr)
        `OFS_FUNC_LOW:    next_regRdata = funcSel[31:0];
        `OFS_FUNC_HIGH:   next_regRdata = {14'h0, funcSel[49:32]};
        `OFS_PULLUP:      next_regRdata = {7'h0, pullupCfg};
        `OFS_CLOCK_RATIO: next_regRdata = {30'h0, clockRatio};
        `OFS_PAD_LEVELS:  next_regRdata = {7'h0, padIn};
        `OFS_STATUS:      next_regRdata = {31'h0, lowPower};
        default:          next_regRdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      funcSel    <= `FUNC_RESET; // R4
      pullupCfg  <= `PULLUP_RESET; // R2
      clockRatio <= `RATIO_RESET;
      regRdata   <= 32'h0;
    end else begin
      funcSel    <= next_funcSel;
      pullupCfg  <= next_pullupCfg;
      clockRatio <= next_clockRatio;
      regRdata   <= next_regRdata;
    end
  end

  // Function-two outputs gathered per pad
  always_comb begin
    altOut = 25'h0;
    altOe  = 25'h0;
    for (int i = 0; i < 4; i++) begin
      altOut[i] = spiMasterSelectN[i];
      altOe[i]  = 1'b1;
    end
    altOe[4]   = 1'b1;
    altOe[5]   = 1'b1;
    // Open drain: drive low only, the board pulls high
    altOe[6]   = i2cSclDriveLow;
    altOe[7]   = i2cSdaDriveLow;
    altOut[10] = spiSlaveTx;
    altOe[10]  = spiSlaveTxOe;
    altOut[12] = uartTx[0];
    altOe[12]  = 1'b1;
    altOut[14] = uartRtsDe[0];
    altOe[14]  = 1'b1;
    altOut[15] = uartCtsReOut[0];
    altOe[15]  = uartCtsReOe[0];
    altOut[16] = spiMasterClock;
    altOe[16]  = 1'b1;
    altOut[17] = spiMasterTx;
    altOe[17]  = 1'b1;
    altOut[19] = pulseOutputZero;
    altOe[19]  = 1'b1;
    altOut[20] = uartTx[1];
    altOe[20]  = 1'b1;
    altOut[22] = uartRtsDe[1];
    altOe[22]  = 1'b1;
    altOut[23] = uartCtsReOut[1];
    altOe[23]  = uartCtsReOe[1];
    altOut[24] = pulseOutputOne;
    altOe[24]  = 1'b1; // R6
  end

  // Per-pad selection; only one function ever reaches a pad
  always_comb begin
    liveOut      = 25'h0;
    liveOe       = 25'h0;
    gpioSel      = 25'h0;
    altSel       = 25'h0;
    analogInputs = 19'h0;
    for (int i = 0; i < `PAD_COUNT; i++) begin
      case (selOf(funcSel, i))
        pad_mux_pkg::FUNC_ZERO: begin
          if (isJtagPad(i)) begin
            // Only the data output pad drives, and only when asked
            if (i == `JTAG_PAD_FIRST) begin
              liveOut[i] = jtagTdo; // R5
              liveOe[i]  = jtagTdoOe; // R1
            end
          end else begin
            gpioSel[i] = 1'b1; // R6
          end
        end
        pad_mux_pkg::FUNC_ONE: begin
          if (isJtagPad(i)) begin
            gpioSel[i] = 1'b1; // R5
          end else if (i < `ANALOG_COUNT) begin
            analogInputs[i] = 1'b1; // R6
          end
        end
        pad_mux_pkg::FUNC_TWO: begin
          altSel[i]  = 1'b1;
          liveOut[i] = altOut[i]; // R7
          liveOe[i]  = altOe[i]; // R7
        end
        default: begin
          liveOe[i] = 1'b0; // R7
        end
      endcase
      if (gpioSel[i]) begin
        liveOut[i] = gpioOut[i];
        liveOe[i]  = gpioOe[i];
      end
    end
  end

  // Pad state frozen in low power, live otherwise
  always_comb begin
    next_padOutReg = lowPower ? padOutReg : liveOut; // R3
    next_padOe     = lowPower ? padOe     : liveOe; // R3
    next_padPullup = lowPower ? padPullup : pullupCfg; // R3
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      padOutReg <= 25'h0;
      padOe     <= 25'h0; // R1
      padPullup <= `PULLUP_RESET; // R2
    end else begin
      padOutReg <= next_padOutReg;
      padOe     <= next_padOe;
      padPullup <= next_padPullup;
    end
  end

  // Clock pads bypass the flops while awake; a registered copy cannot carry them
  always_comb begin
    padOut = padOutReg;
    if (!lowPower && altSel[4]) begin
      padOut[4] = rtcClock; // R9
    end
    if (!lowPower && altSel[5]) begin
      padOut[5] = dividedClock; // R8
    end
  end

  // Peripheral inputs, inactive level when their pad is elsewhere
  always_comb begin
    gpioIn          = padIn & gpioSel; // R14
    spiMasterRx     = altSel[18] ? padIn[18] : 1'b0; // R14
    i2cSclIn        = altSel[6]  ? padIn[6]  : 1'b1; // R14
    i2cSdaIn        = altSel[7]  ? padIn[7]  : 1'b1;
    spiSlaveClock   = altSel[8]  ? padIn[8]  : 1'b0;
    spiSlaveRx      = altSel[9]  ? padIn[9]  : 1'b0;
    spiSlaveSelectN = altSel[11] ? padIn[11] : 1'b1;
    uartRx[0]       = altSel[13] ? padIn[13] : 1'b1;
    uartCts[0]      = altSel[15] ? padIn[15] : 1'b1;
    uartRx[1]       = altSel[21] ? padIn[21] : 1'b1;
    uartCts[1]      = altSel[23] ? padIn[23] : 1'b1;
  end

  // Unselected TAP is held in its own reset
  always_comb begin
    jtagTrstN = 1'b0;
    jtagTck   = 1'b0;
    jtagTms   = 1'b1;
    jtagTdi   = 1'b1;
    if (selOf(funcSel, 20) == pad_mux_pkg::FUNC_ZERO) begin
      jtagTrstN = padIn[20]; // R5
    end
    if (selOf(funcSel, 21) == pad_mux_pkg::FUNC_ZERO) begin
      jtagTck = padIn[21]; // R5
    end
    if (selOf(funcSel, 22) == pad_mux_pkg::FUNC_ZERO) begin
      jtagTms = padIn[22]; // R5
    end
    if (selOf(funcSel, 23) == pad_mux_pkg::FUNC_ZERO) begin
      jtagTdi = padIn[23]; // R5
    end
  end

  // Only the slow comparators stay on to wake the chip
  always_comb begin
    comparatorPowerOn = {{(`ANALOG_COUNT-`FAST_COMP_COUNT){1'b1}},
                         {`FAST_COMP_COUNT{~lowPower}}}; // R12
  end

  // Internal reset is a level path, no clock needed to assert it
  always_comb begin
    internalResetN = resetPinLevel; // R10
    if (batterySupplyRailCycle) begin
      internalResetN = 1'b0; // R11
    end
  end

endmodule

`default_nettype wire

// *** tb/pad_mux_props.sv ***
// Purpose: Port-level properties of the pad mux
// Assumes: Sees only top-level ports
// Notes:   Bound from the bench top file
`default_nettype none

module pad_mux_props (
  // Clock, reset and writes
  input wire logic        clock,
  input wire logic        rstn,
  input wire logic [7:0]  regAddr,
  input wire logic [31:0] regWdata,
  input wire logic        regWrite,
  // Pads and power
  input wire logic [24:0] padOe,
  input wire logic [24:0] padPullup,
  input wire logic        lowPower,
  input wire logic        resetPinLevel,
  input wire logic        batterySupplyRailCycle,
  input wire logic        internalResetN,
  // Analog and GPIO side
  input wire logic [18:0] analogInputs,
  input wire logic [18:0] comparatorPowerOn,
  input wire logic [24:0] gpioIn
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);

  // Low-word pads coded as analog
  function automatic logic [15:0] anaMask(logic [31:0] w);
    for (int i = 0; i < 16; i++) begin
      anaMask[i] = (w[2*i+:2] == 2'h1);
    end
  endfunction

  // Awake write of the low selection word
  sequence lowWrite;
    regWrite && regAddr == 8'h00 && !lowPower;
  endsequence

  // First sample after release still sees reset pad state
  AST_RESET_PADS: assert property (!$past(rstn) |->
    padOe == 25'h0 && padPullup == 25'h0d00000)
    else $error("pad state wrong after reset");
  AST_FREEZE: assert property (lowPower |=>
    $stable(padOe) && $stable(padPullup))
    else $error("pad state moved in low power");
  AST_PIN_HOLD: assert property (!resetPinLevel |-> !internalResetN)
    else $error("internal reset released with pin low");
  AST_BATT: assert property (batterySupplyRailCycle |-> !internalResetN)
    else $error("rail cycle did not reset");
  AST_FAST_OFF: assert property (lowPower |->
    comparatorPowerOn == 19'h7ffc0)
    else $error("comparator power wrong asleep");
  AST_AWAKE_ON: assert property (!lowPower |->
    comparatorPowerOn == 19'h7ffff)
    else $error("comparator power wrong awake");
  AST_ANALOG_SEL: assert property (lowWrite ##1 !lowPower |->
    analogInputs[15:0] == anaMask($past(regWdata)))
    else $error("analog selection not applied");
  AST_ONE_OWNER: assert property ((analogInputs & gpioIn[18:0]) == 19'h0)
    else $error("pad shared by two functions");
endmodule

`default_nettype wire

// *** tb/pad_board_model.sv ***
// Purpose: Board levels seen on the shared pads
// Assumes: Pull-up wins on an undriven pad
// Notes:   Floating pads toggle so stale levels never pass
`default_nettype none

module pad_board_model (
  // Clock
  input  wire logic        clock,
  // Drive from the device
  input  wire logic [24:0] padOut,
  input  wire logic [24:0] padOe,
  input  wire logic [24:0] padPullup,
  // Levels back to the device
  output logic      [24:0] padIn
);
  logic [24:0] wander = 25'h0aaaaaa;

  // Floating level flips every cycle
  always @(posedge clock) wander <= ~wander;

  // Driven pads read back, pulled pads read high
  always_comb padIn = (padOe & padOut) | (~padOe & padPullup)
    | (~padOe & ~padPullup & wander);
endmodule

`default_nettype wire

// *** tb/pad_function_multiplexer_test.sv ***
// Purpose: Self-checking bench for the pad function multiplexer
// Assumes: 40 MHz clock, board model on the pads
// Notes:   Random peripheral levels from a fixed xorshift seed
`default_nettype none

module pad_function_multiplexer_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock, rstn, regWrite, regRead, lowPower, rtcClock;
  logic        resetPinLevel, batterySupplyRailCycle, internalResetN;
  logic [7:0]  regAddr;
  logic [31:0] regWdata, regRdata, seed;
  logic [24:0] padIn, padOut, padOe, padPullup, heldOe, heldOut;
  logic [24:0] gpioOut, gpioOe, gpioIn;
  logic [18:0] analogInputs, comparatorPowerOn;
  logic [3:0]  spiMasterSelectN;
  logic        spiMasterClock, spiMasterTx, spiMasterRx, i2cSclDriveLow;
  logic        i2cSdaDriveLow, i2cSclIn, i2cSdaIn, spiSlaveTx, spiSlaveTxOe;
  logic        spiSlaveClock, spiSlaveRx, spiSlaveSelectN, jtagTdo;
  logic [1:0]  uartTx, uartRtsDe, uartCtsReOut, uartCtsReOe, uartRx, uartCts;
  logic        pulseOutputZero, pulseOutputOne, jtagTdoOe;
  logic        jtagTrstN, jtagTck, jtagTms, jtagTdi;
  int          n_errors, total_checks, ticks, cycles;

  pad_function_multiplexer i_dut (.clock, .rstn, .regAddr, .regWdata,
    .regWrite, .regRead, .regRdata, .padIn, .padOut, .padOe, .padPullup,
    .lowPower, .resetPinLevel, .batterySupplyRailCycle, .internalResetN,
    .rtcClock, .analogInputs, .comparatorPowerOn, .gpioOut, .gpioOe,
    .gpioIn, .spiMasterSelectN, .spiMasterClock, .spiMasterTx,
    .spiMasterRx, .i2cSclDriveLow, .i2cSdaDriveLow, .i2cSclIn, .i2cSdaIn,
    .spiSlaveTx, .spiSlaveTxOe, .spiSlaveClock, .spiSlaveRx,
    .spiSlaveSelectN, .uartTx, .uartRtsDe, .uartCtsReOut, .uartCtsReOe,
    .uartRx, .uartCts, .pulseOutputZero, .pulseOutputOne, .jtagTdo,
    .jtagTdoOe, .jtagTrstN, .jtagTck, .jtagTms, .jtagTdi);
  pad_board_model i_board (.clock, .padOut, .padOe, .padPullup, .padIn);

  // Bus clock and a phase-unrelated slow clock
  initial begin
    clock = 1'h0;
    forever #12.5 clock = ~clock;
  end
  initial begin
    rtcClock = 1'h0;
    forever #170 rtcClock = ~rtcClock;
  end
  // Rising edges of the divided clock pad
  always @(posedge padOut[5]) ticks++;
  // Cut a hang short
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      wrap_up();
    end
  end

  // Random source and expected values
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [31:0] pullups();
    return (32'h1 << 20) | (32'h1 << 22) | (32'h1 << 23);
  endfunction
  // Rising edges of pad 5 in 32 cycles; code 3 acts as the 1:4 ratio
  function automatic int ticksFor(input int code);
    return (code == 0) ? 32 : ((code == 1) ? 16 : 8);
  endfunction

  // Compare and count
  task automatic chk(input string nm, input logic [31:0] s, e);
    total_checks++;
    if (s !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask
  // Register bus cycles
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    regWrite <= 1'h1;
    regAddr  <= a;
    regWdata <= d;
    @(posedge clock);
    regWrite <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clock);
    regRead <= 1'h1;
    regAddr <= a;
    @(posedge clock);
    regRead <= 1'h0;
    #1;
    chk("regRdata", regRdata, e);
  endtask
  // New random peripheral levels, then let pads settle
  task automatic shake();
    logic [31:0] a, b, c;
    a = rnd();
    b = rnd();
    c = rnd();
    gpioOut <= a[24:0];
    gpioOe  <= b[24:0];
    {spiMasterSelectN, spiMasterClock, spiMasterTx, i2cSclDriveLow,
     i2cSdaDriveLow, spiSlaveTx, spiSlaveTxOe, uartTx, uartRtsDe,
     uartCtsReOut, uartCtsReOe, pulseOutputZero, pulseOutputOne,
     jtagTdo, jtagTdoOe} <= c[21:0];
  endtask
  task automatic stir();
    @(posedge clock);
    shake();
    repeat (2) @(posedge clock);
    #1;
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Main sequence
  initial begin
    {regWrite, regRead, lowPower, batterySupplyRailCycle, rstn} = 5'h0;
    resetPinLevel = 1'h1;
    regAddr = 8'h00;
    regWdata = 32'h0;
    seed = 32'h00010ed0;
    shake();
    repeat (2) @(posedge clock);
    rstn <= 1'h1;
    #1;
    chk("padOe", padOe, 25'h0);
    chk("padPullup", padPullup, pullups());
    rd(8'h08, pullups());
    rd(8'h00, 32'h0);
    rd(8'h04, 32'h0);
    rd(8'h20, 32'h0);
    $display("test reset done");
    stir();
    chk("gpioOe", padOe[18:0], gpioOe[18:0]);
    chk("tdoOe", padOe[19], jtagTdoOe);
    chk("tck", jtagTck, padIn[21]);
    chk("gpioIn", gpioIn[23:19], 5'h0);
    $display("test function zero done");
    wr(8'h00, 32'h55555555);
    wr(8'h04, 32'h00015555);
    stir();
    chk("gpioOe", padOe[23:19], gpioOe[23:19]);
    chk("gpioOut", padOut[23:19] & gpioOe[23:19],
        gpioOut[23:19] & gpioOe[23:19]);
    chk("gpioIn", gpioIn[23:19], padIn[23:19]);
    chk("analog", analogInputs, 19'h7ffff);
    chk("analogOe", padOe[18:0], 19'h0);
    chk("uartRx", uartRx, 2'h3);
    chk("trst", jtagTrstN, 1'h0);
    $display("test function one done");
    wr(8'h00, 32'h0a000a00);
    stir();
    chk("uartTx", {padOe[12], padOut[12]}, {1'h1, uartTx[0]});
    chk("uartRx", uartRx[0], padIn[13]);
    repeat (8) begin
      #41;
      chk("rtc", padOut[4], rtcClock);
    end
    for (int r = 0; r < 4; r++) begin
      wr(8'h0c, 32'(r));
      rd(8'h0c, 32'(r));
      ticks = 0;
      repeat (32) @(posedge clock);
      chk("ratio", 1'(ticks >= ticksFor(r) - 1 && ticks <= ticksFor(r) + 1),
          1'h1);
    end
    // Every pad on function two: outputs routed, inputs fed from pads
    wr(8'h00, 32'haaaaaaaa);
    wr(8'h04, 32'h0002aaaa);
    stir();
    chk("spiSel", {padOe[3:0], padOut[3:0]}, {4'hf, spiMasterSelectN});
    chk("i2cDrive", {padOe[7:6], padOut[7:6]},
        {i2cSdaDriveLow, i2cSclDriveLow, 2'h0});
    chk("pulse", {padOe[24], padOut[24], padOe[19], padOut[19]},
        {1'h1, pulseOutputOne, 1'h1, pulseOutputZero});
    chk("altIn", {spiMasterRx, i2cSclIn, i2cSdaIn, spiSlaveClock,
        spiSlaveRx, spiSlaveSelectN, uartCts, uartRx},
        {padIn[18], padIn[6], padIn[7], padIn[8], padIn[9], padIn[11],
         padIn[23], padIn[15], padIn[21], padIn[13]});
    chk("tapIdle", {jtagTrstN, jtagTck, jtagTms, jtagTdi}, 4'h3);
    chk("noGpio", gpioIn, 25'h0);
    $display("test function two done");
    @(posedge clock);
    lowPower <= 1'h1;
    #1;
    heldOe = padOe;
    heldOut = padOut;
    wr(8'h08, 32'h0155aa33);
    rd(8'h14, 32'h1);
    stir();
    chk("frozenOe", padOe, heldOe);
    chk("frozenOut", padOut, heldOut);
    chk("frozenPull", padPullup, pullups());
    chk("fastComp", comparatorPowerOn, 19'h7ffc0);
    @(posedge clock);
    lowPower <= 1'h0;
    stir();
    chk("wake", padOut[12], uartTx[0]);
    chk("pullup", padPullup, 32'h0155aa33);
    chk("comp", comparatorPowerOn, 19'h7ffff);
    rd(8'h14, 32'h0);
    $display("test low power done");
    // Function three everywhere: nothing drives, peripherals see idle
    wr(8'h00, 32'hffffffff);
    wr(8'h04, 32'hffffffff);
    wr(8'h08, 32'h01ffffff);
    stir();
    rd(8'h04, 32'h0003ffff);
    rd(8'h10, 32'h01ffffff);
    chk("unusedOe", padOe, 25'h0);
    chk("unusedOut", padOut, 25'h0);
    chk("idleGpio", gpioIn, 25'h0);
    chk("idleAna", analogInputs, 19'h0);
    chk("idleLow", {spiMasterRx, spiSlaveClock, spiSlaveRx, jtagTrstN,
        jtagTck}, 5'h0);
    chk("idleHigh", {i2cSclIn, i2cSdaIn, spiSlaveSelectN, uartRx, uartCts,
        jtagTms, jtagTdi}, 9'h1ff);
    $display("test function three done");
    for (int i = 0; i < 4; i++) begin
      @(posedge clock);
      {resetPinLevel, batterySupplyRailCycle} <= 2'(i);
      #1;
      chk("intReset", internalResetN, 1'(i == 2));
    end
    $display("test reset pin done");
    wrap_up();
  end
endmodule

bind pad_function_multiplexer pad_mux_props i_props (.clock, .rstn,
  .regAddr, .regWdata, .regWrite, .padOe, .padPullup, .lowPower,
  .resetPinLevel, .batterySupplyRailCycle, .internalResetN,
  .analogInputs, .comparatorPowerOn, .gpioIn);

`default_nettype wire
